//--- cadcm_crate_model.sv
/*
  Crate controller model: runs one dataway cycle for each cmd_go request.
  Assumes the bench holds the cmd fields steady while cmd_go is high.
*/
module cadcm_crate_model (
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic        cmd_go,
  input  wire logic [4:0]  cmd_f,
  input  wire logic [3:0]  cmd_a,
  input  wire logic [15:0] cmd_wdata,
  input  wire logic        q_resp,
  output logic             station_n,
  output logic [4:0]       func,
  output logic [3:0]       subaddr,
  output logic             strobe_s1,
  output logic             strobe_s2,
  output logic [15:0]      write_data,
  output logic             cmd_q,
  output logic             cmd_done
);
  import cadcm_pkg::*;
  logic [1:0] step_q;
  logic       s2_cmd;

  // Clear and self-test go out on S2, mode and channel access on S1
  assign s2_cmd = (cmd_f == F_SELF_TEST) || (cmd_f == F_CLEAR);

  // Strobe cycle, then release with scrambled lines, then take Q
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      step_q     <= 2'h0;
      station_n  <= 1'b0;
      func       <= 5'h00;
      subaddr    <= 4'h0;
      strobe_s1  <= 1'b0;
      strobe_s2  <= 1'b0;
      write_data <= 16'h0000;
      cmd_q      <= 1'b0;
      cmd_done   <= 1'b0;
    end else begin
      strobe_s1 <= 1'b0;
      strobe_s2 <= 1'b0;
      cmd_done  <= 1'b0;
      if (step_q == 2'h0 && cmd_go) begin
        station_n  <= 1'b1;
        func       <= cmd_f;
        subaddr    <= cmd_a;
        write_data <= cmd_wdata;
        strobe_s1  <= !s2_cmd;
        strobe_s2  <= s2_cmd;
        step_q     <= 2'h1;
      end else if (step_q == 2'h1) begin
        // Released lines must not echo the last value
        station_n  <= 1'b0;
        func       <= ~func;
        subaddr    <= ~subaddr;
        write_data <= ~write_data;
        step_q     <= 2'h2;
      end else if (step_q == 2'h2) begin
        cmd_q    <= q_resp;
        cmd_done <= 1'b1;
        step_q   <= 2'h0;
      end
    end
  end
endmodule : cadcm_crate_model

//--- cadcm_mode_control.sv
/*
  Mode control of an eight-channel charge ADC: dataway commands, idle and
  busy sequencing, self-test pulse and gate, mode word and readout steering.
  Assumes the crate controller presents N, F, A and strobes synchronously,
  each strobe a single-cycle pulse; converter arrives one sample per cycle.
*/
module cadcm_mode_control
  import cadcm_pkg::*;
#(
  parameter int CHANNELS = 8
) (
  input  wire logic                  clock,
  input  wire logic                  rstn,
  input  wire logic                  ce,
  input  wire logic                  station_n,
  input  wire logic [4:0]            func,
  input  wire logic [3:0]            subaddr,
  input  wire logic                  strobe_s1,
  input  wire logic                  strobe_s2,
  input  wire logic                  init_z,
  input  wire logic                  clear_c,
  input  wire logic                  inhibit_i,
  input  wire logic [15:0]           write_data,
  output logic [15:0]                read_data,
  output logic                       q_resp,
  output logic                       lam,
  input  wire logic                  panel_gate,
  input  wire logic                  panel_clear,
  input  wire logic                  readout_done,
  input  wire logic                  conv_valid,
  input  wire logic [2:0]            conv_channel,
  input  wire logic [ADC_W-1:0]      conv_value,
  input  wire logic [ADC_W-1:0]      lower_window_level,
  input  wire logic [ADC_W-1:0]      upper_window_level,
  output logic                       test_charge,
  output logic                       int_gate,
  output logic                       busy,
  output logic                       convert_all,
  output logic                       sequential_readout_enable,
  output logic                       zero_suppress_enable,
  output logic                       fast_port_select,
  output logic [VSN_W-1:0]           virtual_station_number,
  output logic                       fast_port_word_valid,
  output logic                       overflow_flag,
  output logic [15:0]                data_word
);
  initial begin
    if (CHANNELS != 8) $error("cadcm_mode_control: eight channels only");
  end

  // How it works
  // RL1: F25 A0 on S2 starts test, Q=1
  // RL2: Test accepted only while idle
  // RL3: Test injects charge, gate at pulse peak
  // RL4: No panel gate during a running test
  // RL5: Value at or above 3840 flags overflow
  // RL6: Mode write F20 A14 S1, read F4 A14
  // RL7: Mode access only idle, Q true accepted
  // RL8: Init Z sets six mode bits, keeps number
  // RL9: Other clears leave mode word untouched
  // RL10: Low eight bits hold virtual station number
  // RL11: Channel tag bit clears data bits 13-15
  // RL12: Port bit picks fast port or dataway
  // RL13: Overflow tag bit clears data bit 16
  // RL14: Sequential plus suppress converts windowed channels
  // RL15: Sequential without suppress converts all eight
  // RL16: Addressed mode reads with F0/F2, A0-7
  // RL17: LAM only when enabled and data waits
  // RL18: Gate moves idle to busy; refuse until clear
  // RL19: Commands outside idle ignored, Q false; code still answers channel reads with Q true in busy
  // RL20: Mode bits 9 and 16 read zero

  cadcm_state_t      state_q, state_d;
  logic [15:0]       mode_q;
  logic [7:0]        tcnt_q;
  logic [CHANNELS-1:0] held_q;
  logic [CHANNELS-1:0][15:0] mem_q;
  logic              q_q;

  // Function decode
  wire addr_ok  = station_n;
  wire is_idle  = (state_q == CADCM_IDLE);
  wire cmd_test = addr_ok && strobe_s2 && func == F_SELF_TEST && subaddr == A_TEST;
  wire cmd_wr   = addr_ok && strobe_s1 && func == F_WRITE_MODE && subaddr == A_MODE;
  wire cmd_rd   = addr_ok && strobe_s1 && func == F_READ_MODE && subaddr == A_MODE;
  wire cmd_clr  = addr_ok && strobe_s2 && func == F_CLEAR && subaddr == A_CLEAR;
  wire cmd_chrd = addr_ok && strobe_s1 && (func == F_READ_CH || func == F_READ_CLR)
                  && !subaddr[3];
  wire cmd_chcl = cmd_chrd && func == F_READ_CLR;
  wire test_ok  = cmd_test && is_idle;  // [RL2]
  wire wr_ok    = cmd_wr && is_idle;    // [RL7]
  wire rd_ok    = cmd_rd && is_idle;    // [RL7]
  wire any_clear = init_z || clear_c || cmd_clr || panel_clear || readout_done;

  // Mode fields
  assign virtual_station_number    = mode_q[VSN_LSB +: VSN_W];  // [RL10]
  assign fast_port_select          = mode_q[BIT_FAST_PORT];
  assign zero_suppress_enable      = mode_q[BIT_ZERO_SUP];
  assign sequential_readout_enable = mode_q[BIT_SEQ];
  wire   lam_enable                = mode_q[BIT_LAM_EN];
  wire   seq_sup = sequential_readout_enable && zero_suppress_enable;
  // Addressed or plain sequential converts every channel
  assign convert_all = !seq_sup;  // [RL15] [RL16]

  // Window test decides which channels count in sequential mode with zero suppression
  wire in_window = conv_value >= lower_window_level && conv_value <= upper_window_level;
  wire keep_conv = conv_valid && state_q == CADCM_BUSY && (!seq_sup || in_window);  // [RL14]

  wire        tag_valid;
  wire [15:0] tag_word;
  wire        tag_ovf;
  logic [2:0] tag_ch_q;

  cadcm_tagger #(.CH_W(3)) u_tagger (
    .clock         (clock),
    .rstn          (rstn),
    .ce            (ce),
    .conv_valid    (keep_conv),
    .conv_channel  (conv_channel),
    .conv_value    (conv_value),
    .chan_tag_off  (mode_q[BIT_CHAN_TAG]),
    .ovf_tag_off   (mode_q[BIT_OVF_TAG]),
    .word_valid    (tag_valid),
    .word_data     (tag_word),
    .word_overflow (tag_ovf)
  );

  assign data_word     = tag_word;
  assign overflow_flag = tag_ovf;
  // Fast port sees words only when selected and sequential
  assign fast_port_word_valid = tag_valid && fast_port_select && sequential_readout_enable;  // [RL12]

  wire gate_in = panel_gate && !inhibit_i;  // Panel gate assumed quiet in test [RL4]

  // Sequencer
  always_comb begin
    state_d = state_q;
    case (state_q)
      CADCM_IDLE: begin
        if (test_ok) state_d = CADCM_TEST;
        else if (gate_in) state_d = CADCM_BUSY;  // [RL18]
      end
      CADCM_TEST: begin
        if (any_clear) state_d = CADCM_IDLE;
        else if (tcnt_q == 8'(TEST_PEAK_CYC + GATE_W_CYC)) state_d = CADCM_BUSY;  // [RL18]
      end
      CADCM_BUSY: begin
        if (any_clear) state_d = CADCM_IDLE;  // Gates refused meanwhile [RL18]
      end
      default: state_d = CADCM_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) state_q <= CADCM_IDLE;
    else if (ce) state_q <= state_d;
  end

  // Test pulse timer; gate centred on the pulse peak
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) tcnt_q <= 8'h00;
    else if (ce) tcnt_q <= (state_q == CADCM_TEST) ? tcnt_q + 8'h01 : 8'h00;
  end
  assign test_charge = (state_q == CADCM_TEST);  // [RL3]
  assign int_gate = test_charge && tcnt_q >= 8'(TEST_PEAK_CYC - GATE_W_CYC / 2)
                    && tcnt_q < 8'(TEST_PEAK_CYC + GATE_W_CYC / 2);  // [RL3]
  assign busy = (state_q != CADCM_IDLE);

  // Mode word: undefined at power-up, shown as zero; only Z touches it
  // besides a write, so ordinary clears keep the setup.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) mode_q <= MODE_RESET;
    else if (ce) begin
      if (init_z) mode_q <= mode_q | MODE_INIT_SET;  // [RL8] [RL9]
      else if (wr_ok) mode_q <= write_data & MODE_WR_MASK;  // [RL6] [RL20]
    end
  end

  // Channel store for dataway reads; held bits mark waiting data
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) tag_ch_q <= 3'h0;
    else if (ce && keep_conv) tag_ch_q <= conv_channel;
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      held_q <= '0;
      mem_q  <= '0;
    end else if (ce) begin
      if (any_clear) held_q <= '0;
      else begin
        if (cmd_chcl && !fast_port_select) held_q[subaddr[2:0]] <= 1'b0;
        if (tag_valid && !fast_port_select) begin  // [RL12]
          held_q[tag_ch_q] <= 1'b1;
          mem_q[tag_ch_q]  <= tag_word;
        end
      end
    end
  end

  // Dataway answers
  wire ch_ok = cmd_chrd && !fast_port_select && held_q[subaddr[2:0]];  // [RL16] [RL12]
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      q_q       <= 1'b0;
      read_data <= 16'h0000;
    end else if (ce) begin
      q_q <= test_ok || wr_ok || rd_ok || ch_ok;  // [RL1] [RL7] [RL19]
      if (rd_ok) read_data <= mode_q & MODE_WR_MASK;  // [RL6] [RL20]
      else if (ch_ok) read_data <= mem_q[subaddr[2:0]];
    end
  end
  assign q_resp = q_q;
  assign lam = lam_enable && !fast_port_select && |held_q;  // [RL17]

  chk_test_q: assert property (@(posedge clock) disable iff (!rstn)
    ce && cmd_test |=> q_resp == $past(is_idle))  // [RL1]
    else $error("test Q wrong");
  chk_test_idle: assert property (@(posedge clock) disable iff (!rstn)
    ce && cmd_test && !is_idle && !any_clear |=> state_q != CADCM_TEST)  // [RL2]
    else $error("test accepted while busy");
  sequence s_test_run;
    test_ok ##1 test_charge;
  endsequence
  chk_test_gate: assert property (@(posedge clock) disable iff (!rstn)
    ce && test_ok && !any_clear |=> test_charge ##[1:120] int_gate)  // [RL3]
    else $error("test gate missing");
  chk_mode_rd: assert property (@(posedge clock) disable iff (!rstn)
    ce && rd_ok |=> q_resp && read_data == $past(mode_q))  // [RL6]
    else $error("mode read wrong");
  chk_init_bits: assert property (@(posedge clock) disable iff (!rstn)
    ce && init_z |=> mode_q[14:9] == 6'h3F && mode_q[7:0] == $past(mode_q[7:0]))  // [RL8]
    else $error("init did not set mode bits");
  chk_clear_keep: assert property (@(posedge clock) disable iff (!rstn)
    ce && !init_z && !wr_ok |=> $stable(mode_q))  // [RL9]
    else $error("mode word changed");
  chk_reserved: assert property (@(posedge clock) disable iff (!rstn)
    !mode_q[8] && !mode_q[15])  // [RL20]
    else $error("reserved mode bits set");
  chk_lam_off: assert property (@(posedge clock) disable iff (!rstn)
    !lam_enable |-> !lam)  // [RL17]
    else $error("LAM while disabled");
  chk_busy_hold: assert property (@(posedge clock) disable iff (!rstn)
    ce && state_q == CADCM_BUSY && !any_clear |=> state_q == CADCM_BUSY)  // [RL18]
    else $error("busy left without clear");
  chk_reject_q: assert property (@(posedge clock) disable iff (!rstn)
    ce && (cmd_wr || cmd_rd) && !is_idle && !ch_ok |=> !q_resp)  // [RL19]
    else $error("Q true outside idle");
endmodule : cadcm_mode_control

//--- cadcm_mode_control_bench.sv
/*
  Self-checking bench of the mode control block with a crate controller model.
  Assumes a 200 MHz clock; window bounds and clock enable stay fixed.
*/
module cadcm_mode_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import cadcm_pkg::*;
  logic clock, rstn, ce, station_n, strobe_s1, strobe_s2, init_z, clear_c, inhibit_i;
  logic q_resp, lam, panel_gate, panel_clear, readout_done, conv_valid, test_charge;
  logic int_gate, busy, convert_all, sequential_readout_enable, zero_suppress_enable;
  logic fast_port_select, fast_port_word_valid, overflow_flag, cmd_go, cmd_q, cmd_done;
  logic [2:0]       conv_channel, ch;
  logic [11:0]      conv_value, lower_window_level, upper_window_level, v;
  logic [4:0]       func, cmd_f;
  logic [3:0]       subaddr, cmd_a;
  logic [15:0]      write_data, read_data, data_word, cmd_wdata, m;
  logic [VSN_W-1:0] virtual_station_number;
  logic [31:0]      seed;
  logic             kept;
  int               errors, num_checks, n;

  cadcm_mode_control i_cadcm_mode_control (.clock, .rstn, .ce, .station_n, .func, .subaddr,
    .strobe_s1, .strobe_s2, .init_z, .clear_c, .inhibit_i, .write_data, .read_data, .q_resp,
    .lam, .panel_gate, .panel_clear, .readout_done, .conv_valid, .conv_channel, .conv_value,
    .lower_window_level, .upper_window_level, .test_charge, .int_gate, .busy, .convert_all,
    .sequential_readout_enable, .zero_suppress_enable, .fast_port_select,
    .virtual_station_number, .fast_port_word_valid, .overflow_flag, .data_word);
  cadcm_crate_model i_cadcm_crate_model (.clock, .rstn, .cmd_go, .cmd_f, .cmd_a, .cmd_wdata,
    .q_resp, .station_n, .func, .subaddr, .strobe_s1, .strobe_s2, .write_data, .cmd_q,
    .cmd_done);

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return x[0] ? ((x >> 1) ^ 32'h80200003) : (x >> 1);
  endfunction : lfsr

  // Tagged data word: overflow on top, channel number below it, value at the bottom
  function automatic logic [15:0] word_of(input logic [15:0] md, input logic [2:0] c,
                                          input logic [11:0] val);
    return {(val >= 12'hF00) & ~md[BIT_OVF_TAG], md[BIT_CHAN_TAG] ? 3'h0 : c, val};
  endfunction : word_of

  task automatic chk_word(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_word

  task automatic chk_flag(input string what, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_flag

  // One dataway cycle; returns on the edge after the answer was taken
  task automatic dw(input logic [4:0] f, input logic [3:0] a, input logic [15:0] d);
    int k;
    k = 0;
    cmd_f <= f;
    cmd_a <= a;
    cmd_wdata <= d;
    cmd_go <= 1'b1;
    @(posedge clock);
    cmd_go <= 1'b0;
    do begin
      @(negedge clock);
      k++;
    end while (cmd_done !== 1'b1 && k < 20);
    @(posedge clock);
  endtask : dw

  task automatic rd_mode(input logic [15:0] exp);
    dw(F_READ_MODE, A_MODE, 16'h0000);
    chk_flag("mode read q", 1'b1, cmd_q);
    chk_word("mode word", exp, read_data);
  endtask : rd_mode

  task automatic print_verdict();
    if (errors == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict

  // Free-running 200 MHz clock
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // Watchdog: the whole run needs well under this many cycles
  initial begin
    repeat (30000) @(posedge clock);
    errors++;
    print_verdict();
  end

  // Main sequence; panel_gate stays low through the self
  initial begin
    {rstn, init_z, clear_c, inhibit_i, panel_gate, panel_clear} = 6'h00;
    {readout_done, conv_valid, cmd_go, conv_channel, conv_value} = 18'h00000;
    {cmd_f, cmd_a, cmd_wdata} = 25'h0000000;
    ce = 1'b1;
    lower_window_level = 12'h100;
    upper_window_level = 12'hFFF;
    seed = 32'hEC70BBC4;
    errors = 0;
    num_checks = 0;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    // Mode writes in idle, all-ones and all-zeros first
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      m = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : seed[15:0];
      dw(F_WRITE_MODE, A_MODE, m);
      chk_flag("write q", 1'b1, cmd_q);
      rd_mode(m & 16'h7EFF);
      chk_word("station", {8'h00, m[7:0]}, {8'h00, virtual_station_number});
      chk_word("fields", {m[13], m[12], m[10]}, {sequential_readout_enable,
               zero_suppress_enable, fast_port_select});
    end
    // Ordinary clears keep the mode word, Z sets the six bits only
    {clear_c, panel_clear, readout_done} <= 3'h7;
    @(posedge clock);
    {clear_c, panel_clear, readout_done} <= 3'h0;
    dw(F_CLEAR, A_CLEAR, 16'h0000);
    rd_mode(m & 16'h7EFF);
    init_z <= 1'b1;
    @(posedge clock);
    init_z <= 1'b0;
    @(posedge clock);
    m = (m & 16'h00FF) | 16'h7E00;
    rd_mode(m);
    // Self-test: gate lies inside the charge pulse, then busy refuses commands
    dw(F_SELF_TEST, A_TEST, 16'h0000);
    chk_flag("test q", 1'b1, cmd_q);
    n = 0;
    repeat (400) begin
      @(negedge clock);
      if (int_gate === 1'b1) begin
        n++;
        chk_flag("charge at gate", 1'b1, test_charge);
      end
    end
    chk_word("gate width", 16'(GATE_W_CYC), 16'(n));
    chk_flag("test busy", 1'b1, busy);
    @(posedge clock);
    dw(F_SELF_TEST, A_TEST, 16'h0000);
    chk_flag("busy test q", 1'b0, cmd_q);
    dw(F_WRITE_MODE, A_MODE, 16'h0000);
    chk_flag("busy write q", 1'b0, cmd_q);
    dw(F_READ_MODE, A_MODE, 16'h0000);
    chk_flag("busy read q", 1'b0, cmd_q);
    dw(F_CLEAR, A_CLEAR, 16'h0000);
    rd_mode(m);
    // Acquisitions under random modes, overflow edges and a dropped sample
    for (int i = 0; i < 20; i++) begin
      seed = lfsr(seed);
      m = seed[15:0] & 16'h7EFF;
      ch = seed[18:16];
      v = (i < 3) ? 12'hEFF + 12'(i) : (i == 3) ? 12'h050 : seed[31:20];
      if (i == 3) m[13:12] = 2'b11;
      kept = !(m[13] & m[12]) || (v >= 12'h100);
      dw(F_CLEAR, A_CLEAR, 16'h0000);
      dw(F_WRITE_MODE, A_MODE, m);
      chk_flag("convert all", !(m[13] & m[12]), convert_all);
      panel_gate <= 1'b1;
      repeat (2) @(posedge clock);
      panel_gate <= 1'b0;
      n = 0;
      do begin
        @(negedge clock);
        n++;
      end while (busy !== 1'b1 && n < 300);
      chk_flag("gate to busy", 1'b1, busy);
      @(posedge clock);
      conv_channel <= ch;
      conv_value <= v;
      conv_valid <= 1'b1;
      @(posedge clock);
      conv_valid <= 1'b0;
      @(negedge clock);
      if (kept) begin
        chk_word("data word", word_of(m, ch, v), data_word);
        chk_flag("overflow", v >= 12'hF00, overflow_flag);
        chk_flag("fast word", m[10] & m[13], fast_port_word_valid);
      end
      // The waiting mark lands one edge after the tagged word
      @(negedge clock);
      chk_flag("lam", kept & m[14] & !m[10], lam);
      @(posedge clock);
      dw(F_READ_CH, {1'b0, ch}, 16'h0000);
      if (m[10]) chk_flag("fast port read q", 1'b0, cmd_q);
      if (!m[13] && !m[10]) begin
        chk_flag("read q", 1'b1, cmd_q);
        chk_word("read word", word_of(m, ch, v), read_data);
        dw(F_READ_CLR, {1'b0, ch}, 16'h0000);
        chk_flag("read clear q", 1'b1, cmd_q);
        dw(F_READ_CH, {1'b0, ch}, 16'h0000);
        chk_flag("cleared read q", 1'b0, cmd_q);
      end
    end
    print_verdict();
  end
endmodule : cadcm_mode_control_bench

//--- cadcm_pkg.sv
/*
  Package for the charge ADC mode control block: dataway function codes,
  subaddresses, mode word field positions, overflow limit and test timing.
  Assumes a 200 MHz clock and dataway strobes already synchronous to it.
*/
package cadcm_pkg;
  // Dataway function and subaddress codes
  localparam logic [4:0] F_READ_CH    = 5'h00;
  localparam logic [4:0] F_READ_CLR   = 5'h02;
  localparam logic [4:0] F_READ_MODE  = 5'h04;
  localparam logic [4:0] F_CLEAR      = 5'h09;
  localparam logic [4:0] F_WRITE_MODE = 5'h14;
  localparam logic [4:0] F_SELF_TEST  = 5'h19;
  localparam logic [3:0] A_MODE       = 4'hE;
  localparam logic [3:0] A_TEST       = 4'h0;
  localparam logic [3:0] A_CLEAR      = 4'h0;

  // Mode word layout
  localparam int VSN_LSB       = 0;
  localparam int VSN_W         = 8;
  localparam int BIT_CHAN_TAG  = 9;   // Mode bit R10
  localparam int BIT_FAST_PORT = 10;  // R11
  localparam int BIT_OVF_TAG   = 11;  // R12
  localparam int BIT_ZERO_SUP  = 12;  // R13
  localparam int BIT_SEQ       = 13;  // R14
  localparam int BIT_LAM_EN    = 14;  // R15
  localparam logic [15:0] MODE_WR_MASK  = 16'h7EFF;
  localparam logic [15:0] MODE_INIT_SET = 16'h7E00;
  localparam logic [15:0] MODE_RESET    = 16'h0000;

  // Data word layout
  localparam int DW_CH_LSB = 12;  // R13..R15
  localparam int DW_OVF    = 15;  // R16

  // Conversion limits
  localparam int          ADC_W     = 12;
  localparam logic [11:0] OVF_LIMIT = 12'hF00;  // 3840

  // Timing
  localparam int CLK_MHZ      = 200;
  localparam int TEST_PEAK_NS = 500;
  localparam int TEST_PEAK_CYC = (TEST_PEAK_NS * CLK_MHZ) / 1000;
  localparam int GATE_W_NS    = 100;
  localparam int GATE_W_CYC   = (GATE_W_NS * CLK_MHZ) / 1000;

  typedef enum logic [1:0] {
    CADCM_IDLE = 2'b00,
    CADCM_TEST = 2'b01,
    CADCM_BUSY = 2'b11
  } cadcm_state_t;
endpackage : cadcm_pkg

//--- cadcm_tagger.sv
/*
  Data word former: flags overflow and tags channel and overflow bits
  according to the mode word. Assumes a one-cycle valid on conv_valid.
*/
module cadcm_tagger
  import cadcm_pkg::*;
#(
  parameter int CH_W = 3
) (
  input  wire logic              clock,
  input  wire logic              rstn,
  input  wire logic              ce,
  input  wire logic              conv_valid,
  input  wire logic [CH_W-1:0]   conv_channel,
  input  wire logic [ADC_W-1:0]  conv_value,
  input  wire logic              chan_tag_off,
  input  wire logic              ovf_tag_off,
  output logic                   word_valid,
  output logic [15:0]            word_data,
  output logic                   word_overflow
);
  initial begin
    if (CH_W != 3) $error("cadcm_tagger: channel field is three bits");
  end

  // Values in the reserved top codes are invalid
  wire is_ovf = (conv_value >= OVF_LIMIT);  // [RL5]
  wire [15:0] word_d = {(is_ovf & ~ovf_tag_off),  // [RL13]
                        (chan_tag_off ? 3'h0 : conv_channel),  // [RL11]
                        conv_value};

  // Registered so the data output holds steady for the reader
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      word_valid    <= 1'b0;
      word_data     <= 16'h0000;
      word_overflow <= 1'b0;
    end else if (ce) begin
      word_valid <= conv_valid;
      if (conv_valid) begin
        word_data     <= word_d;
        word_overflow <= is_ovf;
      end
    end
  end

  chk_ovf_flag: assert property (@(posedge clock) disable iff (!rstn)
    ce && conv_valid |=> word_overflow == ($past(conv_value) >= OVF_LIMIT))  // [RL5]
    else $error("overflow flag wrong");
  chk_tag_bits: assert property (@(posedge clock) disable iff (!rstn)
    ce && conv_valid && $past(1'b1) && chan_tag_off |=> word_data[14:12] == 3'h0)  // [RL11]
    else $error("channel tag not cleared");
  chk_ovf_bit: assert property (@(posedge clock) disable iff (!rstn)
    ce && conv_valid && ovf_tag_off |=> !word_data[DW_OVF])  // [RL13]
    else $error("overflow tag not cleared");
endmodule : cadcm_tagger
